// ==== strid_core_model.sv ====
/*
 * Behavioural model of the SCSI core and bus behind the register group.
 * Assumes its tasks are called right after a rising clock edge.
 */
module strid_core_model (
    input wire logic sys_clk_in,
    output logic sel_attempt_out,
    output logic bus_free_out,
    output logic arbitrating_out,
    output logic [15:0] bus_ids_out,
    output logic [3:0] offset_count_out,
    output logic [3:0] max_offset_out,
    output logic [15:0] fifo_word_out,
    output logic [1:0] fifo_par_out
);
    initial begin
        sel_attempt_out = 1'b0;
        bus_free_out = 1'b0;
        arbitrating_out = 1'b0;
        bus_ids_out = 16'h0000;
        offset_count_out = 4'h0;
        max_offset_out = 4'h5;
        // Lanes differ so a swapped parity pair shows
        fifo_word_out = 16'hA55A;
        fifo_par_out = 2'h2;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic drive(input logic [15:0] ids, input logic free,
                         input logic arb, input logic [3:0] cnt,
                         input logic [3:0] mx);
        bus_ids_out <= ids;
        bus_free_out <= free;
        arbitrating_out <= arb;
        offset_count_out <= cnt;
        max_offset_out <= mx;
    endtask
    // Attempt held two cycles; the bus is then released, no IDs asserted
    task automatic select(input logic [15:0] ids);
        sel_attempt_out <= 1'b1;
        bus_ids_out <= ids;
        repeat (2) @(posedge sys_clk_in);
        sel_attempt_out <= 1'b0;
        bus_ids_out <= 16'h0000;
    endtask
endmodule // strid_core_model

// ==== strid_gp_timer.sv ====
/*
 * General purpose timer in 100 us ticks, doubling per period code.
 * Assumes run is held for the whole timed interval.
 */
module strid_gp_timer #(
    parameter int TICK_CYC = strid_pkg::GP_TICK_CYC
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    strid_tmr_if.tmr t
);
    import strid_pkg::*;
    localparam int TW = $clog2(TICK_CYC + 1);
    logic [TW-1:0] tick_q;
    logic [GP_CNT_W-1:0] cnt_q;
    logic done_q;
    logic exp_q;
    wire active = t.run && (t.period != 4'h0);
    wire tick = (tick_q == TW'(TICK_CYC - 1));
    wire [GP_CNT_W-1:0] base = GP_CNT_W'(1) << (t.period - 4'h1);
    wire [GP_CNT_W-1:0] limit = t.scale ? (base << SCALE_SHIFT) : base;
    wire hit = active && tick && !done_q && (cnt_q + 1'b1 == limit);
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !active) begin
            tick_q <= '0;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            tick_q <= tick ? '0 : tick_q + 1'b1;
            cnt_q <= (tick && !done_q) ? cnt_q + 1'b1 : cnt_q;
            done_q <= done_q | hit;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        exp_q <= nrst_in && hit;
    end
    assign t.expired = exp_q;
endmodule // strid_gp_timer

// ==== strid_pkg.sv ====
/*
 * Shared constants for the SCSI test and response ID register group.
 * Assumes a 250 MHz system clock and APB word access at byte 4*index.
 */
package strid_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    ////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [9:0] IDX_IRQ_STAT = 10'h040;
    localparam logic [9:0] IDX_IRQ_EN = 10'h041;
    localparam logic [9:0] IDX_CHIP_ID = 10'h042;
    localparam logic [9:0] IDX_OCL = 10'h044;
    localparam logic [9:0] IDX_TIMER1 = 10'h049;
    localparam logic [9:0] IDX_RESP_LO = 10'h04A;
    localparam logic [9:0] IDX_RESP_HI = 10'h04B;
    localparam logic [9:0] IDX_STATUS = 10'h04C;
    localparam logic [9:0] IDX_DBL = 10'h04D;
    localparam logic [9:0] IDX_TCTL = 10'h04E;
    localparam logic [9:0] IDX_TCTLX = 10'h04F;
    localparam logic [9:0] IDX_ODL = 10'h054;
    localparam logic [9:0] IDX_ODL_HI = 10'h055;
    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int TC_OVERRIDE = 7;
    localparam int TC_OFS_CLR = 6;
    localparam int TC_DIF = 5;
    localparam int TC_LOOP = 4;
    localparam int TC_HIZ = 3;
    localparam int TC_WIDE = 2;
    localparam int TC_FILT = 1;
    localparam int TC_LOW = 0;
    localparam int TX_NEG = 7;
    localparam int TX_STR = 6;
    localparam int TX_HALT = 5;
    localparam int DB_EN = 3;
    localparam int DB_SEL = 2;
    localparam int TM_SCALE = 5;
    localparam int IRQ_GP = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    // Control line order: rst req ack bsy sel atn msg cd io
    localparam logic [8:0] DIF_MASK = 9'h130;
    localparam logic [8:0] NEG_MASK = 9'h0C0;
    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int GP_TICK_NS = 100000;
    localparam int GP_TICK_CYC = GP_TICK_NS / CLK_PERIOD_NS;
    localparam int SCALE_SHIFT = 4;
    localparam int GP_CNT_W = 19;
endpackage

// ==== strid_prio.sv ====
/*
 * Highest set bit encoder.
 * Assumes a purely combinational use by its parent.
 */
module strid_prio #(
    parameter int W = 16
) (
    input wire logic [W-1:0] vec_in,
    output logic hit_out,
    output logic [$clog2(W)-1:0] idx_out
);
    always_comb begin
        idx_out = '0;
        for (int i = 0; i < W; i++) begin
            if (vec_in[i]) begin
                idx_out = i[$clog2(W)-1:0];
            end
        end
    end
    assign hit_out = |vec_in;
endmodule // strid_prio

// ==== strid_regs.sv ====
/*
 * SCSI test, response ID and timer register group with APB slave.
 * Assumes the SCSI core supplies assert vectors, offset count and FIFO
 * word, and that pad and clock logic act on the control outputs.
 */
// How it works
// - Timer runs while enabled; expiry sets sticky flag, irq gated by bit 1
// - Period code 0 disables; 100 us doubling per code; scale multiplies by 16
// - Respond to selection on any ID set in the two response maps
// - Status bit 3 shows ready for selection, ignoring the settle delay
// - Status bit 2 shows own ID is highest during arbitration
// - Status bit 1 is live: offset count equals zero
// - Status bit 0 is live: offset count equals programmed maximum
// - Doubler powered by bit 3; bit 2 doubles only with bit 3
// - Doubler turns a 40-50 MHz clock into 80-100 MHz
// - Bits 1-0 hold parity of FIFO lanes last read via the latch
// - Override bit lets software drive every line except RST from the latches
// - Offset clear bit clears outstanding offset then clears itself
// - Differential bit tristates BSY, SEL and RST drivers
// - Loopback runs both roles; high-impedance bit floats every driver
// - Force-wide bit makes every information phase 16 bits wide
// - REQ/ACK glitch filter is 30 ns, or 60 ns when extended
// - Low-level mode stops DMA and fetches and blocks selection response
// - Active negation drives deasserted levels only in information phases
// - Test read of full latch unloads FIFO; high byte alone does not
// - Clock halt bit stops the divided SCSI clock cleanly
module strid_regs #(
    parameter int TICK_CYC = strid_pkg::GP_TICK_CYC
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [strid_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic gp_timer_run_in,
    input wire logic sel_attempt_in,
    input wire logic bus_free_in,
    input wire logic arbitrating_in,
    input wire logic [15:0] bus_ids_in,
    input wire logic [3:0] offset_count_in,
    input wire logic [3:0] max_offset_in,
    input wire logic [15:0] fifo_word_in,
    input wire logic [1:0] fifo_par_in,
    input wire logic info_phase_in,
    input wire logic [8:0] core_ctl_assert_in,
    input wire logic [17:0] core_dat_assert_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    output logic gp_irq_out,
    output logic selected_out,
    output logic offset_clear_out,
    output logic fifo_unload_out,
    output logic doubler_power_on_out,
    output logic doubler_select_out,
    output logic scsi_clock_halt_out,
    output logic core_loopback_out,
    output logic force_wide_out,
    output logic filter_extend_out,
    output logic low_level_out,
    output logic [8:0] scsi_ctl_out,
    output logic [8:0] scsi_ctl_oe_out,
    output logic [17:0] scsi_dat_out,
    output logic [17:0] scsi_dat_oe_out
);
    import strid_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] resp_lo_q, resp_hi_q, tctl_q, ocl_q, timer1_q;
    logic [2:0] tctlx_q;
    logic [1:0] dbl_q, fpar_q;
    logic [3:0] chip_id_q, sel_id_q;
    logic gp_flag_q, gp_en_q, wait_q;
    logic [15:0] odl_q;
    strid_tmr_if tmr ();
    ////////////////////////////////////////////////////////////////////////
    // APB decode; one wait state so every answer comes from a flop
    wire [IDX_W-1:0] idx = paddr_in[ADDR_W-1:2];
    wire access = psel_in && penable_in;
    wire fire = access && wait_q;
    wire wr = fire && pwrite_in;
    wire rd = fire && !pwrite_in;
    wire hit_rlo = (idx == IDX_RESP_LO);
    wire hit_rhi = (idx == IDX_RESP_HI);
    wire hit_stat = (idx == IDX_STATUS);
    wire hit_dbl = (idx == IDX_DBL);
    wire hit_tctl = (idx == IDX_TCTL);
    wire hit_tctlx = (idx == IDX_TCTLX);
    wire hit_tim = (idx == IDX_TIMER1);
    wire hit_ist = (idx == IDX_IRQ_STAT);
    wire hit_ien = (idx == IDX_IRQ_EN);
    wire hit_cid = (idx == IDX_CHIP_ID);
    wire hit_ocl = (idx == IDX_OCL);
    wire hit_odl = (idx == IDX_ODL);
    wire hit_odh = (idx == IDX_ODL_HI);
    wire mapped = hit_rlo | hit_rhi | hit_stat | hit_dbl | hit_tctl
        | hit_tctlx | hit_tim | hit_ist | hit_ien | hit_cid | hit_ocl
        | hit_odl | hit_odh;
    wire [7:0] wb = pwdata_in[7:0];
    ////////////////////////////////////////////////////////////////////////
    // Selection, arbitration and offset status
    wire [15:0] resp_map = {resp_hi_q, resp_lo_q};
    wire [15:0] match = bus_ids_in & resp_map;
    wire sel_any;
    wire [3:0] sel_idx;
    wire arb_any;
    wire [3:0] arb_idx;
    strid_prio #(.W(16)) u_sel_prio (
        .vec_in(match),
        .hit_out(sel_any),
        .idx_out(sel_idx)
    );
    strid_prio #(.W(16)) u_arb_prio (
        .vec_in(bus_ids_in),
        .hit_out(arb_any),
        .idx_out(arb_idx)
    );
    wire low = tctl_q[TC_LOW];
    wire sel_hit = sel_attempt_in && sel_any && !low;
    wire sel_ready = bus_free_in && (resp_map != RST_HALF) && !low;
    wire arb_win = arbitrating_in && arb_any
        && (arb_idx == chip_id_q);
    wire ofs_zero = (offset_count_in == 4'h0);
    wire ofs_max = (offset_count_in == max_offset_in);
    wire [7:0] status = {sel_id_q, sel_ready, arb_win, ofs_zero, ofs_max};
    ////////////////////////////////////////////////////////////////////////
    // FIFO test read: full latch read unloads, high byte alone does not
    wire str_on = tctlx_q[TX_STR - 5];
    wire unload = rd && hit_odl && str_on;
    wire [15:0] odl_view = str_on ? fifo_word_in : odl_q;
    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved and unmapped bits read as zero
    wire [7:0] rb =
        hit_rlo ? resp_lo_q :
        hit_rhi ? resp_hi_q :
        hit_stat ? status :
        hit_dbl ? {4'h0, dbl_q, fpar_q} :
        hit_tctl ? tctl_q :
        hit_tctlx ? {tctlx_q, 5'h00} :
        hit_tim ? timer1_q :
        hit_ist ? {6'h00, gp_flag_q, 1'b0} :
        hit_ien ? {6'h00, gp_en_q, 1'b0} :
        hit_cid ? {4'h0, chip_id_q} :
        hit_ocl ? ocl_q :
        hit_odh ? odl_view[15:8] : RST_BYTE;
    wire [31:0] rdata = hit_odl ? {16'h0000, odl_view} : {24'h000000, rb};
    ////////////////////////////////////////////////////////////////////////
    // Line drive: override, differential, high impedance, negation
    wire ovr = tctl_q[TC_OVERRIDE];
    wire [8:0] ctl_asrt = ovr ? {1'b0, ocl_q} : core_ctl_assert_in;
    wire [17:0] dat_asrt = ovr
        ? {~^odl_q[15:8], ~^odl_q[7:0], odl_q} : core_dat_assert_in;
    wire neg = tctlx_q[TX_NEG - 5] && info_phase_in;
    wire hiz = tctl_q[TC_HIZ];
    wire [8:0] ctl_keep = (tctl_q[TC_DIF] ? ~DIF_MASK : 9'h1FF)
        & {9{!hiz}};
    wire [8:0] ctl_oe_d = (ctl_asrt | (neg ? NEG_MASK : 9'h000)) & ctl_keep;
    wire [17:0] dat_oe_d = (dat_asrt | {18{neg}}) & {18{!hiz}};
    ////////////////////////////////////////////////////////////////////////
    // Timer link
    assign tmr.period = timer1_q[3:0];
    assign tmr.scale = timer1_q[TM_SCALE];
    assign tmr.run = gp_timer_run_in;
    strid_gp_timer #(.TICK_CYC(TICK_CYC)) u_timer (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .t(tmr)
    );
    wire flag_clr = wr && hit_ist && wb[IRQ_GP];
    ////////////////////////////////////////////////////////////////////////
    // APB handshake and read data
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            wait_q <= 1'b0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            wait_q <= access && !wait_q;
            pready_out <= access && !wait_q;
            pslverr_out <= access && !wait_q && !mapped;
            prdata_out <= (access && !wait_q && !pwrite_in) ? rdata
                : 32'h00000000;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Software registers; status bits take no writes
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            resp_lo_q <= RST_BYTE;
            resp_hi_q <= RST_BYTE;
            tctl_q <= RST_BYTE;
            tctlx_q <= 3'h0;
            dbl_q <= 2'h0;
            timer1_q <= RST_BYTE;
            gp_en_q <= 1'b0;
            chip_id_q <= 4'h0;
            ocl_q <= RST_BYTE;
            odl_q <= RST_HALF;
        end else begin
            if (wr && hit_rlo) resp_lo_q <= wb;
            if (wr && hit_rhi) resp_hi_q <= wb;
            if (wr && hit_tctl) begin
                tctl_q <= wb;
            end else begin
                tctl_q[TC_OFS_CLR] <= 1'b0;
            end
            if (wr && hit_tctlx) tctlx_q <= wb[7:5];
            if (wr && hit_dbl) dbl_q <= wb[3:2];
            if (wr && hit_tim) timer1_q <= wb & 8'h3F;
            if (wr && hit_ien) gp_en_q <= wb[IRQ_GP];
            if (wr && hit_cid) chip_id_q <= wb[3:0];
            if (wr && hit_ocl) ocl_q <= wb;
            if (wr && hit_odl) odl_q <= pwdata_in[15:0];
            if (wr && hit_odh) odl_q[15:8] <= wb;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Hardware status capture
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            gp_flag_q <= 1'b0;
            sel_id_q <= 4'h0;
            fpar_q <= 2'h0;
        end else begin
            // Set wins over a same-cycle clear, so no expiry is lost
            gp_flag_q <= tmr.expired | (gp_flag_q & !flag_clr);
            if (sel_hit) sel_id_q <= sel_idx;
            if (unload) fpar_q <= fifo_par_in;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Registered control outputs
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            gp_irq_out <= 1'b0;
            selected_out <= 1'b0;
            offset_clear_out <= 1'b0;
            fifo_unload_out <= 1'b0;
            doubler_power_on_out <= 1'b0;
            doubler_select_out <= 1'b0;
            scsi_clock_halt_out <= 1'b0;
            core_loopback_out <= 1'b0;
            force_wide_out <= 1'b0;
            filter_extend_out <= 1'b0;
            low_level_out <= 1'b0;
            scsi_ctl_out <= 9'h1FF;
            scsi_ctl_oe_out <= 9'h000;
            scsi_dat_out <= 18'h3FFFF;
            scsi_dat_oe_out <= 18'h00000;
        end else begin
            gp_irq_out <= gp_flag_q && gp_en_q;
            selected_out <= sel_hit;
            offset_clear_out <= tctl_q[TC_OFS_CLR];
            fifo_unload_out <= unload;
            doubler_power_on_out <= dbl_q[DB_EN - 2];
            doubler_select_out <= dbl_q[DB_EN - 2] && dbl_q[DB_SEL - 2];
            scsi_clock_halt_out <= tctlx_q[TX_HALT - 5];
            core_loopback_out <= tctl_q[TC_LOOP];
            force_wide_out <= tctl_q[TC_WIDE];
            filter_extend_out <= tctl_q[TC_FILT];
            low_level_out <= low;
            // Asserted lines pull low; negated driven lines go high
            scsi_ctl_out <= ~ctl_asrt;
            scsi_ctl_oe_out <= ctl_oe_d;
            scsi_dat_out <= ~dat_asrt;
            scsi_dat_oe_out <= dat_oe_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Checks; one clock domain, so clock and reset are given once
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    flag_set_a: assert property (
        tmr.expired |=> gp_flag_q)
        else $error("timer expiry did not set flag");
    irq_gate_a: assert property (
        ##1 gp_irq_out == $past(gp_flag_q && gp_en_q))
        else $error("interrupt not gated by enable");
    timer_off_a: assert property (
        (timer1_q[3:0] == 4'h0) [*2] |-> !tmr.expired)
        else $error("disabled timer expired");
    id_cap_a: assert property (
        sel_hit |=> (sel_id_q == $past(sel_idx)) && selected_out)
        else $error("selected id not captured");
    low_sel_a: assert property (
        low |=> !selected_out)
        else $error("selection answered in low level mode");
    ofs_clr_a: assert property (
        wr && hit_tctl && wb[TC_OFS_CLR] |=> ##1 offset_clear_out
        ##1 !offset_clear_out)
        else $error("offset clear not a single pulse");
    dbl_dep_a: assert property (
        doubler_select_out |-> doubler_power_on_out)
        else $error("doubler selected while powered down");
    hiz_all_a: assert property (
        hiz |=> scsi_ctl_oe_out == 9'h000 && scsi_dat_oe_out == 18'h00000)
        else $error("driver enabled in high impedance mode");
    dif_pads_a: assert property (
        tctl_q[TC_DIF] |=> (scsi_ctl_oe_out & DIF_MASK) == 9'h000)
        else $error("differential pads driven");
    hi_read_a: assert property (
        rd && hit_odh |=> !fifo_unload_out)
        else $error("high byte read unloaded fifo");
    expiry_c: cover property (gp_irq_out);
    select_c: cover property (selected_out);
    unload_c: cover property (fifo_unload_out);
    override_c: cover property (ovr && scsi_dat_oe_out != 18'h00000);
endmodule // strid_regs

// ==== strid_regs_bench.sv ====
/*
 * Self-checking bench of the register group over APB.
 * Assumes strid_pkg and the SCSI side model are compiled first.
 */
module strid_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import strid_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, sel, ofs_clr, unload, dbl_on, dbl_sel;
    logic halt, loop, wide, filt, low;
    logic att, free, arb;
    logic [15:0] ids, fword;
    logic [3:0] cnt, mx;
    logic [1:0] fpar;
    logic [8:0] ctl_oe, ctl_lvl, core_ctl = 9'h000;
    logic [17:0] dat_oe, dat_lvl;
    logic info = 1'b0;
    int failures = 0, n_tests = 0;
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    strid_core_model p (.sys_clk_in(clk), .sel_attempt_out(att),
        .bus_free_out(free), .arbitrating_out(arb), .bus_ids_out(ids),
        .offset_count_out(cnt), .max_offset_out(mx),
        .fifo_word_out(fword), .fifo_par_out(fpar));
    // Small tick keeps timer runs short
    strid_regs #(.TICK_CYC(4)) DUT (.sys_clk_in(clk), .nrst_in(nrst),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .gp_timer_run_in(run),
        .sel_attempt_in(att), .bus_free_in(free), .arbitrating_in(arb),
        .bus_ids_in(ids), .offset_count_in(cnt), .max_offset_in(mx),
        .fifo_word_in(fword), .fifo_par_in(fpar), .info_phase_in(info),
        .core_ctl_assert_in(core_ctl), .core_dat_assert_in(18'h00000),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .gp_irq_out(irq), .selected_out(sel), .offset_clear_out(ofs_clr),
        .fifo_unload_out(unload), .doubler_power_on_out(dbl_on),
        .doubler_select_out(dbl_sel), .scsi_clock_halt_out(halt),
        .core_loopback_out(loop), .force_wide_out(wide),
        .filter_extend_out(filt), .low_level_out(low),
        .scsi_ctl_out(ctl_lvl), .scsi_ctl_oe_out(ctl_oe),
        .scsi_dat_out(dat_lvl), .scsi_dat_oe_out(dat_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until pready is sampled high, then released
    task automatic xfer(input logic w, input logic [9:0] idx,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        int n;
        n = 0;
        // Idle edge first, so back-to-back calls never reassign psel at once
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] m,
                      input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, idx, 32'h0, r, e);
        chk(r & m, exp);
    endtask
    // Watch one pulse or level for lim edges
    task automatic see(input int k, input int lim, input logic exp);
        logic hit;
        hit = 1'b0;
        repeat (lim) begin
            @(posedge clk);
            case (k)
                0: hit |= (sel === 1'b1);
                1: hit |= (ofs_clr === 1'b1);
                2: hit |= (unload === 1'b1);
                default: hit |= (irq === 1'b1);
            endcase
        end
        chk(32'(hit), 32'(exp));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(IDX_TCTL, 32'hFF, 32'h00);
        rd(IDX_DBL, 32'h0C, 32'h00);
        chk(32'(ctl_oe), 32'h0);
        $display("test reset done");
        wr(IDX_RESP_LO, 32'h01);
        wr(IDX_RESP_HI, 32'h80);
        rd(IDX_RESP_HI, 32'hFF, 32'h80);
        fork p.select(16'h8000); see(0, 8, 1'b1); join
        rd(IDX_STATUS, 32'hFF, 32'hF2);
        fork p.select(16'h0002); see(0, 8, 1'b0); join
        wr(IDX_STATUS, 32'h00);
        p.drive(16'h0000, 1'b0, 1'b0, 4'h5, 4'h5);
        rd(IDX_STATUS, 32'hFF, 32'hF1);
        wr(IDX_CHIP_ID, 32'h3);
        p.drive(16'h0008, 1'b1, 1'b1, 4'h5, 4'h5);
        rd(IDX_STATUS, 32'hFF, 32'hFD);
        p.drive(16'h0018, 1'b1, 1'b1, 4'h5, 4'h5);
        rd(IDX_STATUS, 32'hFF, 32'hF9);
        wr(IDX_TCTL, 32'h01);
        rd(IDX_STATUS, 32'h08, 32'h00);
        fork p.select(16'h8000); see(0, 8, 1'b0); join
        $display("test select done");
        wr(IDX_TCTL, 32'h16);
        repeat (2) @(posedge clk);
        chk(32'({loop, wide, filt, low}), 32'hE);
        wr(IDX_TCTL, 32'h40);
        see(1, 6, 1'b1);
        rd(IDX_TCTL, 32'hFF, 32'h00);
        $display("test control done");
        wr(IDX_TCTLX, 32'h80);
        info <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'({ctl_oe, dat_oe}), {5'h00, NEG_MASK, 18'h3FFFF});
        info <= 1'b0;
        wr(IDX_TCTLX, 32'h00);
        core_ctl <= 9'h1FF;
        wr(IDX_TCTL, 32'h20);
        repeat (2) @(posedge clk);
        chk(32'(ctl_oe), 32'h0CF);
        wr(IDX_TCTL, 32'h08);
        repeat (2) @(posedge clk);
        chk(32'({ctl_oe, dat_oe}), 32'h0);
        core_ctl <= 9'h000;
        wr(IDX_OCL, 32'h55);
        wr(IDX_ODL, 32'h1234);
        wr(IDX_TCTL, 32'h80);
        repeat (2) @(posedge clk);
        chk(32'({ctl_oe, dat_oe}), {5'h00, 9'h055, 18'h21234});
        chk(32'({ctl_lvl, dat_lvl}), {5'h00, 9'h1AA, 18'h1EDCB});
        wr(IDX_TCTL, 32'h00);
        $display("test lines done");
        wr(IDX_DBL, 32'h04);
        repeat (2) @(posedge clk);
        chk(32'({dbl_on, dbl_sel}), 32'h0);
        wr(IDX_DBL, 32'h08);
        repeat (5000) @(posedge clk);
        wr(IDX_TCTLX, 32'h20);
        wr(IDX_DBL, 32'h0C);
        repeat (2) @(posedge clk);
        chk(32'({dbl_on, dbl_sel, halt}), 32'h7);
        wr(IDX_TCTLX, 32'h00);
        repeat (2) @(posedge clk);
        chk(32'(halt), 32'h0);
        $display("test doubler done");
        wr(IDX_TCTLX, 32'h40);
        xfer(1'b0, IDX_ODL_HI, 32'h0, r, e);
        chk(r, 32'h000000A5);
        see(2, 3, 1'b0);
        xfer(1'b0, IDX_ODL, 32'h0, r, e);
        chk(r, 32'h0000A55A);
        see(2, 3, 1'b1);
        rd(IDX_DBL, 32'h03, 32'h02);
        $display("test fifo done");
        wr(IDX_IRQ_EN, 32'h02);
        run <= 1'b1;
        see(3, 100, 1'b0);
        run <= 1'b0;
        wr(IDX_TIMER1, 32'h21);
        run <= 1'b1;
        see(3, 50, 1'b0);
        see(3, 40, 1'b1);
        run <= 1'b0;
        wr(IDX_IRQ_STAT, 32'h02);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        wr(IDX_IRQ_EN, 32'h00);
        wr(IDX_TIMER1, 32'h02);
        run <= 1'b1;
        see(3, 40, 1'b0);
        run <= 1'b0;
        rd(IDX_IRQ_STAT, 32'h02, 32'h02);
        $display("test timer done");
        xfer(1'b0, 10'h3FF, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test unmapped done");
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end
endmodule // strid_regs_bench

// ==== strid_tmr_if.sv ====
/*
 * Link between the register group and its general purpose timer.
 * Assumes both ends share sys_clk_in.
 */
interface strid_tmr_if;
    logic [3:0] period;
    logic scale;
    logic run;
    logic expired;
    modport ctl (output period, output scale, output run, input expired);
    modport tmr (input period, input scale, input run, output expired);
endinterface
